// ---- testbench/xbt_tester.sv ----
/*
 Board test equipment model: drives the chain input pins and the bus reset.
 Assumes the bench calls its tasks and that clk is the block clock.
*/
module xbt_tester #(
    parameter int N         = 88,
    parameter int FRAME_IDX = 21,
    parameter int LAD0_IDX  = 17
) (
    input  wire logic         clk,
    output logic              pci_reset_n,
    output logic      [N-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pci_reset_n = 1'b1;
        pin_in      = '0;
    end

    // --------------------
    // Strap and release
    // --------------------
    // Straps stand across the release edge; mode is settled at the first rising edge after release.
    task automatic release_bus(input logic frame, input logic lad0);
        @(negedge clk);
        pci_reset_n         = 1'b0;
        pin_in[FRAME_IDX]   = frame;
        pin_in[LAD0_IDX]    = lad0;
        @(negedge clk);
        pci_reset_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask : release_bus

    task automatic set_pin(input int idx, input logic v);
        @(negedge clk);
        pin_in[idx] = v;
    endtask : set_pin
endmodule : xbt_tester

// ---- testbench/xbt_top_tb.sv ----
/*
 Self-checking bench of the board test block.
 Assumes the block's own files and header are compiled first.
*/
`include "xbt_consts.svh"

module xbt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = `XBT_CHAIN_PINS;

    logic         clk = 1'b0, reset_n = 1'b1, pci_reset_n, test_mode;
    logic [N-1:0] pin_in, func_in, pin_out, pin_oe_n;
    logic [N-1:0] func_out = {11{8'ha5}}, func_oe_n = {11{8'h3c}};
    logic         chain_pin_in = 1'b1, func_chain_out = 1'b1, func_chain_oe_n = 1'b1;
    logic         func_chain_in, chain_pin_out, chain_pin_oe_n, e;
    int           err_total = 0, check_count = 0, cyc = 0;

    always #2 clk = ~clk;

    xbt_tester #(.N(N)) tester_u (.clk(clk), .pci_reset_n(pci_reset_n), .pin_in(pin_in));

    xbt_top #(.N(N)) dut_u (
        .clk(clk), .reset_n(reset_n), .pci_reset_n(pci_reset_n), .pin_in(pin_in),
        .func_out(func_out), .func_oe_n(func_oe_n), .func_in(func_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .chain_pin_in(chain_pin_in),
        .func_chain_out(func_chain_out), .func_chain_oe_n(func_chain_oe_n),
        .func_chain_in(func_chain_in), .chain_pin_out(chain_pin_out),
        .chain_pin_oe_n(chain_pin_oe_n), .test_mode(test_mode));

    // --------------------
    // Checking and closing
    // --------------------
    task automatic chk(input logic [N-1:0] seen, input logic [N-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            complete_run();
        end
    end

    // --------------------
    // Scenarios
    // --------------------
    task automatic t_enter();
        tester_u.release_bus(1'b0, 1'b0);
        chk(test_mode, 1'b1);
        chk(pin_oe_n, '1);
        chk(func_in, '0);
        chk(func_chain_in, 1'b0);
        chk(chain_pin_oe_n, 1'b0);
        chk(chain_pin_out, 1'b0);
        $display("enter done");
    endtask : t_enter

    task automatic t_walk();
        e = 1'b0;
        for (int i = N - 1; i >= 0; i--) begin
            tester_u.set_pin(i, 1'b1);
            #1 e = ~e;
            chk(chain_pin_out, e);
        end
        chk(chain_pin_out, 1'b0);
        chk(test_mode, 1'b1);
        @(negedge clk) chain_pin_in = 1'b0;
        #1 chk(chain_pin_out, 1'b0);
        @(negedge clk) chain_pin_in = 1'b1;
        for (int i = 0; i < N; i++) begin
            tester_u.set_pin(i, 1'b0);
            #1 e = ~e;
            chk(chain_pin_out, e);
        end
        $display("walk done");
    endtask : t_walk

    task automatic t_exit(input logic frame, input logic lad0);
        tester_u.release_bus(frame, lad0);
        chk(test_mode, 1'b0);
        chk(pin_out, func_out);
        chk(pin_oe_n, func_oe_n);
        chk(func_in, pin_in);
        chk(func_chain_in, chain_pin_in);
        chk(chain_pin_oe_n, func_chain_oe_n);
        tester_u.set_pin(5, 1'b1);
        #1 chk(chain_pin_out, func_chain_out);
        tester_u.set_pin(5, 1'b0);
        tester_u.set_pin(frame ? 21 : 17, 1'b0);
        $display("exit done");
    endtask : t_exit

    task automatic t_por();
        t_enter();
        @(negedge clk) reset_n = 1'b0;
        #1 chk(test_mode, 1'b0);
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        chk(test_mode, 1'b0);
        $display("por done");
    endtask : t_por

    initial begin
        #1 reset_n = 1'b0;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        t_enter();
        t_walk();
        t_exit(1'b1, 1'b0);
        t_exit(1'b0, 1'b1);
        t_enter();
        t_exit(1'b0, 1'b1);
        t_por();
        complete_run();
    end
endmodule : xbt_top_tb

// ---- verilog/xbt_chain.sv ----
/*
 Parity chain over all included pins.
 Assumes the caller has already left excluded pins out of the vector.
*/
module xbt_chain #(
    parameter int N = 88
) (
    input  wire logic [N-1:0] pins,
    input  wire logic         enable,
    output logic              parity
);

    // ------------------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------------------
    // An even-length xnor chain equals the xor of its inputs.
    logic acc;

    always_comb begin
        acc = 1'b0;
        for (int i = 0; i < N; i++) begin
            acc = acc ^ pins[i];
        end
    end

    assign parity = enable & acc;

endmodule : xbt_chain

// ---- verilog/xbt_consts.svh ----
/*
 Constants of the board test block: pin counts, chain indices, reset values.
 Assumes inclusion by its bare name from every file that needs them.
*/
`ifndef XBT_CONSTS_SVH
`define XBT_CONSTS_SVH

// ----------------------------------------------------------------------------
// Pin map
// ----------------------------------------------------------------------------
`define XBT_CHAIN_PINS      88
`define XBT_LAD0_IDX        17
`define XBT_FRAME_IDX       21

// ----------------------------------------------------------------------------
// Reset and gated values
// ----------------------------------------------------------------------------
`define XBT_BUS_RST_PREV_RESET 1'b1
`define XBT_FUNC_IN_GATED      1'b0

`endif

// ---- verilog/xbt_pkg.sv ----
/*
 Types of the board test block.
 Assumes nothing of its surroundings.
*/
package xbt_pkg;

    // ------------------------------------------------------------------------
    // Mode
    // ------------------------------------------------------------------------
    typedef enum logic {
        XBT_MODE_NORMAL = 1'b0,
        XBT_MODE_CHAIN  = 1'b1
    } xbt_mode_e;

endpackage : xbt_pkg

// ---- verilog/xbt_top.sv ----
/*
 Board test mode selection and pad muxing around the parity chain.
 Assumes pins sampled synchronously to clk and reset_n is the main supply POR.
*/
`include "xbt_consts.svh"

module xbt_top #(
    parameter int N         = `XBT_CHAIN_PINS,
    parameter int LAD0_IDX  = `XBT_LAD0_IDX,
    parameter int FRAME_IDX = `XBT_FRAME_IDX
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         pci_reset_n,
    input  wire logic [N-1:0] pin_in,
    input  wire logic [N-1:0] func_out,
    input  wire logic [N-1:0] func_oe_n,
    output logic      [N-1:0] func_in,
    output logic      [N-1:0] pin_out,
    output logic      [N-1:0] pin_oe_n,
    input  wire logic         chain_pin_in,
    input  wire logic         func_chain_out,
    input  wire logic         func_chain_oe_n,
    output logic              func_chain_in,
    output logic              chain_pin_out,
    output logic              chain_pin_oe_n,
    output logic              test_mode
);

    // ------------------------------------------------------------------------
    // Bus reset release detection
    // ------------------------------------------------------------------------
    logic              bus_rst_prev_q;
    wire logic         bus_rst_rise;
    wire logic         select_chain;
    xbt_pkg::xbt_mode_e mode_q;
    xbt_pkg::xbt_mode_e mode_d;

    // The previous level resets high, so a bus reset already released at POR gives no edge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rst_prev_q <= `XBT_BUS_RST_PREV_RESET;
        end else begin
            bus_rst_prev_q <= pci_reset_n;
        end
    end

    assign bus_rst_rise = pci_reset_n & ~bus_rst_prev_q;
    assign select_chain = ~pin_in[FRAME_IDX] & ~pin_in[LAD0_IDX];

    // ------------------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------------------
    // The straps only count in the cycle that sees the release edge.
    always_comb begin
        mode_d = mode_q;
        if (bus_rst_rise) begin
            if (select_chain) begin
                mode_d = xbt_pkg::XBT_MODE_CHAIN;
            end else begin
                mode_d = xbt_pkg::XBT_MODE_NORMAL;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= xbt_pkg::XBT_MODE_NORMAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    wire logic in_chain;

    assign in_chain  = (mode_q == xbt_pkg::XBT_MODE_CHAIN);
    assign test_mode = in_chain;

    // ------------------------------------------------------------------------
    // Chain
    // ------------------------------------------------------------------------
    // The vector holds only included pins; the chain pin's own input is unused.
    wire logic chain_result;

    xbt_chain #(
        .N (N)
    ) u_chain (
        .pins   (pin_in),
        .enable (in_chain),
        .parity (chain_result)
    );

    // ------------------------------------------------------------------------
    // Pad muxing
    // ------------------------------------------------------------------------
    // In test mode every pad but the chain pin is released and its data forced low.
    wire logic [N-1:0] gate_vec;

    assign gate_vec       = {N{in_chain}};
    assign pin_oe_n       = func_oe_n | gate_vec;
    assign pin_out        = func_out & ~gate_vec;
    assign func_in        = in_chain ? {N{`XBT_FUNC_IN_GATED}} : pin_in;
    assign chain_pin_out  = in_chain ? chain_result : func_chain_out;
    assign chain_pin_oe_n = in_chain ? 1'b0 : func_chain_oe_n;
    assign func_chain_in  = in_chain ? `XBT_FUNC_IN_GATED : chain_pin_in;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking

    default disable iff (!reset_n);

    property p_enter;
        bus_rst_rise && !pin_in[FRAME_IDX] && !pin_in[LAD0_IDX] |=> test_mode;
    endproperty
    a_enter: assert property (p_enter) else $error("Test mode not entered.");

    property p_exit;
        bus_rst_rise && (pin_in[FRAME_IDX] || pin_in[LAD0_IDX]) |=> !test_mode;
    endproperty
    a_exit: assert property (p_exit) else $error("Test mode not left.");

    property p_all_inputs;
        test_mode |-> (&pin_oe_n) && (func_in == '0) && !func_chain_in;
    endproperty
    a_all_inputs: assert property (p_all_inputs) else $error("Pin driven in test mode.");

    property p_drive_out;
        test_mode |-> !chain_pin_oe_n && (chain_pin_out == ^pin_in);
    endproperty
    a_drive_out: assert property (p_drive_out) else $error("Chain output wrong.");

    property p_own_pin_out;
        test_mode && $past(test_mode) && $changed(chain_pin_in) && $stable(pin_in)
            |-> $stable(chain_pin_out);
    endproperty
    a_own_pin_out: assert property (p_own_pin_out) else $error("Output pin in chain.");

    property p_toggle;
        test_mode && $past(test_mode) && ($countones(pin_in ^ $past(pin_in)) == 1)
            |-> (chain_pin_out != $past(chain_pin_out));
    endproperty
    a_toggle: assert property (p_toggle) else $error("Chain did not toggle.");

    property p_frame_in_chain;
        test_mode && $past(test_mode)
            && ($changed(pin_in[FRAME_IDX]) || $changed(pin_in[LAD0_IDX]))
            && ($countones(pin_in ^ $past(pin_in)) == 1)
            |-> (chain_pin_out != $past(chain_pin_out));
    endproperty
    a_frame_in_chain: assert property (p_frame_in_chain) else $error("Strap pin ignored.");

    property p_por;
        disable iff (1'b0) !reset_n && $past(!reset_n) |-> !test_mode;
    endproperty
    a_por: assert property (p_por) else $error("Mode kept through POR.");

    property p_normal_out;
        !test_mode |-> (chain_pin_out == func_chain_out)
            && (chain_pin_oe_n == func_chain_oe_n);
    endproperty
    a_normal_out: assert property (p_normal_out) else $error("Chain leaks out.");

    property p_all_low;
        test_mode && (pin_in == '0) |-> !chain_pin_out;
    endproperty
    a_all_low: assert property (p_all_low) else $error("All low not low.");

    property p_all_high;
        test_mode && (&pin_in) |-> !chain_pin_out;
    endproperty
    a_all_high: assert property (p_all_high) else $error("All high not low.");

    property p_hold;
        !bus_rst_rise |=> $stable(test_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("Mode changed off edge.");

    property p_restore;
        !test_mode |-> (pin_out == func_out) && (pin_oe_n == func_oe_n)
            && (func_in == pin_in);
    endproperty
    a_restore: assert property (p_restore) else $error("Normal pins not restored.");

    property p_test_pads_low;
        test_mode |-> (pin_out == '0);
    endproperty
    a_test_pads_low: assert property (p_test_pads_low) else $error("Pad data driven in test mode.");

    property p_strap_ignored;
        test_mode && !bus_rst_rise |=> test_mode;
    endproperty
    a_strap_ignored: assert property (p_strap_ignored) else $error("Test mode left off edge.");

    property p_cov_enter;
        !test_mode ##1 test_mode;
    endproperty
    c_enter: cover property (p_cov_enter);

    property p_cov_exit;
        test_mode ##1 !test_mode;
    endproperty
    c_exit: cover property (p_cov_exit);

    property p_cov_toggle;
        test_mode && $rose(chain_pin_out) ##1 test_mode && $fell(chain_pin_out);
    endproperty
    c_toggle: cover property (p_cov_toggle);

    property p_cov_all_high;
        test_mode && (&pin_in);
    endproperty
    c_all_high: cover property (p_cov_all_high);

    property p_cov_strap_move;
        test_mode && $changed(pin_in[FRAME_IDX]) ##1 test_mode;
    endproperty
    c_strap_move: cover property (p_cov_strap_move);

endmodule : xbt_top
